// ---- rtl/tlbc_loopback.sv ----
// T1/E1 loopback selector for one transceiver: control register plus the
// data and timing steering among formatter, framer and line interface.
// Assumes clk_in far faster than any line clock; pin clocks are sampled
// and their rising edges detected. Formatter and framer strobes are
// synchronous to clk_in.
`timescale 1ns/10ps

module tlbc_loopback
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       ce_in,
	// Register port
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wr_data_in,
	input  wire logic       wr_en_in,
	input  wire logic       rd_en_in,
	output logic      [7:0] rd_data_out,
	// Mode from the framer configuration
	input  wire logic       t1_mode_in,
	// Pins and line interface, outside clk_in's domain
	input  wire logic       tx_clk_in,
	input  wire logic       rx_line_clk_in,
	input  wire logic       liu_rec_clk_in,
	input  wire logic       framer_tx_clk_in,
	input  wire logic       line_rx_pos_in,
	input  wire logic       line_rx_neg_in,
	input  wire logic       liu_rx_pos_in,
	input  wire logic       liu_rx_neg_in,
	input  wire logic       framer_tx_pos_in,
	input  wire logic       framer_tx_neg_in,
	input  wire logic       mux_pin_in,
	// Formatter and framer side, same domain
	input  wire logic       fmt_pos_in,
	input  wire logic       fmt_neg_in,
	input  wire logic       fmt_chan_clk_in,
	input  wire logic       fmt_chan_block_in,
	input  wire logic       tx_frame_start_in,
	input  wire logic       rx_frame_start_in,
	// Line side outputs
	output logic            line_tx_pos_out,
	output logic            line_tx_neg_out,
	output logic            tx_link_clk_out,
	output logic            tx_chan_clk_out,
	output logic            tx_chan_block_out,
	// Framer receive inputs as steered here
	output logic            rx_fr_pos_out,
	output logic            rx_fr_neg_out,
	output logic            rx_fr_clk_out,
	// Steering flags
	output logic            tx_user_ignore_out,
	output logic            tx_payload_loop_out,
	output logic            liu_joined_out,
	output logic            tx_power_down_out
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [tlbc_pkg::SYNC_COUNT-1:0] pin_raw;
	logic [tlbc_pkg::SYNC_COUNT-1:0] sync_a;
	logic [tlbc_pkg::SYNC_COUNT-1:0] sync_b;

	assign pin_raw = {mux_pin_in, framer_tx_neg_in, framer_tx_pos_in, liu_rx_neg_in, liu_rx_pos_in,
		line_rx_neg_in, line_rx_pos_in, framer_tx_clk_in, liu_rec_clk_in, rx_line_clk_in, tx_clk_in};

	// Two flops per pin; only sync_b is read by logic
	genvar gi;
	generate
		for (gi = 0; gi < tlbc_pkg::SYNC_COUNT; gi++)
		begin : g_sync
			always_ff @(posedge clk_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
				begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end
				else if (ce_in)
				begin
					sync_a[gi] <= pin_raw[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Control register and frame-aligned active copy
	// ------------------------------------------------------------------
	logic [7:0] loopback_control;
	logic [7:0] next_loopback_control;
	logic       framer_loop_en;
	logic       next_framer_loop_en;
	logic       payload_loop_en;
	logic       next_payload_loop_en;
	logic       remote_loop_en;
	logic       next_remote_loop_en;
	logic       local_loop_en;
	logic       next_local_loop_en;
	logic [7:0] next_rd_data;
	logic       liu_mux_ctl;
	logic       mux_pin_func_sel;

	assign liu_mux_ctl      = loopback_control[tlbc_pkg::LIU_MUX_CTL_BIT];
	assign mux_pin_func_sel = loopback_control[tlbc_pkg::MUX_PIN_FUNC_SEL_BIT];

	// Writes land at once; loop modes follow only at frame starts so no
	// partial frame leaves on the line
	always_comb
	begin
		next_loopback_control = loopback_control;
		next_rd_data          = rd_data_out;
		if (wr_en_in && addr_in == tlbc_pkg::LOOPBACK_CONTROL_ADDR)
			next_loopback_control = wr_data_in & tlbc_pkg::WRITABLE_MASK; // Bits 5,6 held zero
		if (rd_en_in)
			next_rd_data = (addr_in == tlbc_pkg::LOOPBACK_CONTROL_ADDR) ? loopback_control : 8'h00;
		next_framer_loop_en  = framer_loop_en;
		next_remote_loop_en  = remote_loop_en;
		next_local_loop_en   = local_loop_en;
		next_payload_loop_en = payload_loop_en;
		if (tx_frame_start_in)
		begin
			next_framer_loop_en = loopback_control[tlbc_pkg::FRAMER_LOOP_EN_BIT];
			next_remote_loop_en = loopback_control[tlbc_pkg::REMOTE_LOOP_EN_BIT];
			next_local_loop_en  = loopback_control[tlbc_pkg::LOCAL_LOOP_EN_BIT];
		end
		if (rx_frame_start_in)
			next_payload_loop_en = loopback_control[tlbc_pkg::PAYLOAD_LOOP_EN_BIT];
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			loopback_control <= tlbc_pkg::LOOPBACK_CONTROL_RESET;
			rd_data_out      <= 8'h00;
			framer_loop_en   <= 1'b0;
			payload_loop_en  <= 1'b0;
			remote_loop_en   <= 1'b0;
			local_loop_en    <= 1'b0;
		end
		else if (ce_in)
		begin
			loopback_control <= next_loopback_control;
			rd_data_out      <= next_rd_data;
			framer_loop_en   <= next_framer_loop_en;
			payload_loop_en  <= next_payload_loop_en;
			remote_loop_en   <= next_remote_loop_en;
			local_loop_en    <= next_local_loop_en;
		end
	end

	// ------------------------------------------------------------------
	// Mux pin role and LIU joining
	// ------------------------------------------------------------------
	logic mux_pin;
	logic joined;

	assign mux_pin = sync_b[tlbc_pkg::SYNC_MUX_PIN];
	// Select bit or pin high hands control to the mux bit
	// Both low keeps the parts separated whatever the mux bit
	assign joined = (mux_pin_func_sel || mux_pin) ? !liu_mux_ctl : 1'b0;

	// ------------------------------------------------------------------
	// Clock selection and edge detection
	// ------------------------------------------------------------------
	logic tx_clk_lvl;
	logic rec_clk_lvl;
	logic line_clk_sel;
	logic rx_clk_sel;
	logic line_clk_d;
	logic rx_clk_d;
	logic line_edge;
	logic rx_edge;

	// Separated parts use the framer-side pins for clocks
	assign tx_clk_lvl  = joined ? sync_b[tlbc_pkg::SYNC_TX_CLK] : sync_b[tlbc_pkg::SYNC_FR_TX_CLK];
	assign rec_clk_lvl = joined ? sync_b[tlbc_pkg::SYNC_LIU_REC_CLK] : sync_b[tlbc_pkg::SYNC_RX_LINE_CLK];
	// Line side on recovered clock in payload or remote loop
	assign line_clk_sel = (payload_loop_en || remote_loop_en) ? rec_clk_lvl : tx_clk_lvl;
	// Receive side follows transmit clock in framer loop
	assign rx_clk_sel = framer_loop_en ? tx_clk_lvl : rec_clk_lvl;
	assign line_edge  = line_clk_sel && !line_clk_d;
	assign rx_edge    = rx_clk_sel && !rx_clk_d;

	// ------------------------------------------------------------------
	// Data steering
	// ------------------------------------------------------------------
	logic                           rx_pos_lvl;
	logic                           rx_neg_lvl;
	logic                           src_pos;
	logic                           src_neg;
	logic                           ones_pol;
	logic                           next_ones_pol;
	logic [tlbc_pkg::BIT_CNT_W-1:0] bit_cnt;
	logic [tlbc_pkg::BIT_CNT_W-1:0] next_bit_cnt;
	logic [tlbc_pkg::BIT_CNT_W-1:0] oh_bits;
	logic                           in_payload;
	logic                           next_line_pos;
	logic                           next_line_neg;
	logic                           next_rx_pos;
	logic                           next_rx_neg;

	assign rx_pos_lvl = joined ? sync_b[tlbc_pkg::SYNC_LIU_RXP] : sync_b[tlbc_pkg::SYNC_LINE_RXP];
	assign rx_neg_lvl = joined ? sync_b[tlbc_pkg::SYNC_LIU_RXN] : sync_b[tlbc_pkg::SYNC_LINE_RXN];
	assign src_pos    = joined ? fmt_pos_in : sync_b[tlbc_pkg::SYNC_FR_TXP];
	assign src_neg    = joined ? fmt_neg_in : sync_b[tlbc_pkg::SYNC_FR_TXN];

	// Overhead bits per frame: T1 one framing bit, E1 the whole first slot
	assign oh_bits = t1_mode_in ?
		tlbc_pkg::BIT_CNT_W'(tlbc_pkg::T1_FRAME_BITS - tlbc_pkg::T1_PAYLOAD_BITS) :
		tlbc_pkg::BIT_CNT_W'(tlbc_pkg::E1_FRAME_BITS - tlbc_pkg::E1_PAYLOAD_BITS);
	assign in_payload = (bit_cnt >= oh_bits);

	// Line and receive data, each updated on its own selected clock edge
	always_comb
	begin
		next_line_pos = line_tx_pos_out;
		next_line_neg = line_tx_neg_out;
		next_ones_pol = ones_pol;
		next_bit_cnt  = bit_cnt;
		next_rx_pos   = rx_fr_pos_out;
		next_rx_neg   = rx_fr_neg_out;
		if (tx_frame_start_in)
			next_bit_cnt = '0;
		else if (line_edge && bit_cnt != tlbc_pkg::BIT_CNT_W'(tlbc_pkg::E1_FRAME_BITS - 1))
			next_bit_cnt = bit_cnt + 1'b1;
		if (line_edge)
		begin
			if (remote_loop_en)
			begin
				// Formatter dropped, line input echoed
				next_line_pos = rx_pos_lvl;
				next_line_neg = rx_neg_lvl;
			end
			else if (framer_loop_en && t1_mode_in)
			begin
				// Unframed all ones, marks alternating polarity
				next_line_pos = !ones_pol;
				next_line_neg = ones_pol;
				next_ones_pol = !ones_pol;
			end
			else
			begin
				// Normal data, also in E1 framer loop
				next_line_pos = src_pos;
				next_line_neg = src_neg;
			end
		end
		if (rx_edge)
		begin
			if (framer_loop_en)
			begin
				// Transmit data looped in, line input ignored
				next_rx_pos = src_pos;
				next_rx_neg = src_neg;
			end
			else if (local_loop_en)
			begin
				// Receive pair replaced by what goes out
				next_rx_pos = line_tx_pos_out;
				next_rx_neg = line_tx_neg_out;
			end
			else
			begin
				// Remote loop still feeds the framer normally
				next_rx_pos = rx_pos_lvl;
				next_rx_neg = rx_neg_lvl;
			end
		end
	end

	// ------------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------------
	// Every output is a flop so glitches of the muxes never reach pins
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			line_clk_d          <= 1'b0;
			rx_clk_d            <= 1'b0;
			ones_pol            <= 1'b0;
			bit_cnt             <= '0;
			line_tx_pos_out     <= 1'b0;
			line_tx_neg_out     <= 1'b0;
			rx_fr_pos_out       <= 1'b0;
			rx_fr_neg_out       <= 1'b0;
			tx_link_clk_out     <= 1'b0;
			rx_fr_clk_out       <= 1'b0;
			tx_chan_clk_out     <= 1'b0;
			tx_chan_block_out   <= 1'b0;
			tx_user_ignore_out  <= 1'b0;
			tx_payload_loop_out <= 1'b0;
			liu_joined_out      <= 1'b0;
			tx_power_down_out   <= 1'b0;
		end
		else if (ce_in)
		begin
			line_clk_d          <= line_clk_sel;
			rx_clk_d            <= rx_clk_sel;
			ones_pol            <= next_ones_pol;
			bit_cnt             <= next_bit_cnt;
			line_tx_pos_out     <= next_line_pos;
			line_tx_neg_out     <= next_line_neg;
			rx_fr_pos_out       <= next_rx_pos;
			rx_fr_neg_out       <= next_rx_neg;
			tx_link_clk_out     <= line_clk_sel;
			rx_fr_clk_out       <= rx_clk_sel;
			tx_chan_clk_out     <= fmt_chan_clk_in && !payload_loop_en;
			tx_chan_block_out   <= fmt_chan_block_in && !payload_loop_en;
			tx_user_ignore_out  <= payload_loop_en || remote_loop_en;
			// Payload positions only; overhead regenerated by formatter
			tx_payload_loop_out <= payload_loop_en && in_payload;
			liu_joined_out      <= joined;
			tx_power_down_out   <= mux_pin_func_sel && mux_pin;
		end
	end

endmodule : tlbc_loopback

// ---- rtl/tlbc_pkg.sv ----
// Constants shared by the T1/E1 loopback selector: register map, fields,
// reset values and frame geometry.
// Assumes an 8-bit register port in the same clock domain as the selector.
package tlbc_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] LOOPBACK_CONTROL_ADDR  = 8'h4a;
	localparam logic [7:0] LOOPBACK_CONTROL_RESET = 8'h00;

	// ------------------------------------------------------------------
	// Field positions in the loopback control register
	// ------------------------------------------------------------------
	localparam int FRAMER_LOOP_EN_BIT   = 0;
	localparam int PAYLOAD_LOOP_EN_BIT  = 1;
	localparam int REMOTE_LOOP_EN_BIT   = 2;
	localparam int LOCAL_LOOP_EN_BIT    = 3;
	localparam int LIU_MUX_CTL_BIT      = 4;
	localparam int MUX_PIN_FUNC_SEL_BIT = 7;
	localparam logic [7:0] WRITABLE_MASK = 8'h9f;

	// ------------------------------------------------------------------
	// Frame geometry, counted in line bits
	// ------------------------------------------------------------------
	localparam int T1_FRAME_BITS    = 193;
	localparam int T1_PAYLOAD_BITS  = 192;
	localparam int E1_FRAME_BITS    = 256;
	localparam int E1_PAYLOAD_BITS  = 248;
	localparam int BIT_CNT_W        = 9;

	// ------------------------------------------------------------------
	// Pin synchroniser slots
	// ------------------------------------------------------------------
	localparam int SYNC_TX_CLK     = 0;
	localparam int SYNC_RX_LINE_CLK = 1;
	localparam int SYNC_LIU_REC_CLK = 2;
	localparam int SYNC_FR_TX_CLK  = 3;
	localparam int SYNC_LINE_RXP   = 4;
	localparam int SYNC_LINE_RXN   = 5;
	localparam int SYNC_LIU_RXP    = 6;
	localparam int SYNC_LIU_RXN    = 7;
	localparam int SYNC_FR_TXP     = 8;
	localparam int SYNC_FR_TXN     = 9;
	localparam int SYNC_MUX_PIN    = 10;
	localparam int SYNC_COUNT      = 11;

endpackage : tlbc_pkg

// ---- verif/tlbc_line_model.sv ----
// Line-side model: recovered clock and receive data from the line interface.
// Assumes the bench samples its outputs from its own clock domain.
`timescale 1ns/10ps

module tlbc_line_model
(
	output logic rec_clk_out,
	output logic rx_pos_out,
	output logic rx_neg_out
);
	// --------
	// Free-running clock, own phase; data moves on falling edges
	// --------
	initial
	begin
		rec_clk_out = 1'b0;
		rx_pos_out  = 1'b0;
		rx_neg_out  = 1'b1;
		// No per-channel loop is exercised, so the clocks may stay apart
		#37;  // Never aligned to the transmit clock
		forever
		begin
			#80 rec_clk_out = ~rec_clk_out;
			if (!rec_clk_out)
			begin
				rx_pos_out = 1'($urandom);
				rx_neg_out = ~rx_pos_out;  // One mark per bit, never both rails
			end
		end
	end
endmodule : tlbc_line_model

// ---- verif/tlbc_loopback_sva.sv ----
// Port assertions for the loopback selector.
// Assumes one clock domain and the design package compiled first.
`timescale 1ns/10ps

module tlbc_loopback_chk
(
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic       ce_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic       wr_en_in,
	input wire logic       rd_en_in,
	input wire logic [7:0] rd_data_out,
	input wire logic       tx_clk_in,
	input wire logic       rx_line_clk_in,
	input wire logic       liu_rec_clk_in,
	input wire logic       framer_tx_clk_in,
	input wire logic       mux_pin_in,
	input wire logic       tx_frame_start_in,
	input wire logic       rx_frame_start_in,
	input wire logic       line_tx_pos_out,
	input wire logic       tx_chan_clk_out,
	input wire logic       tx_chan_block_out,
	input wire logic       tx_user_ignore_out,
	input wire logic       tx_payload_loop_out,
	input wire logic       liu_joined_out,
	input wire logic       tx_power_down_out
);
	logic [7:0] shadow, next_shadow, hist, next_hist;
	logic [3:0] clks_q;
	logic [2:0] calm, next_calm;
	logic       pin_q;

	// --------
	// Shadow register, pin clock edges, settle count
	// --------
	always_comb
	begin
		next_shadow = shadow;
		if (wr_en_in && ce_in && addr_in == tlbc_pkg::LOOPBACK_CONTROL_ADDR)
			next_shadow = wr_data_in & tlbc_pkg::WRITABLE_MASK;
		next_hist = {hist[6:0], |({tx_clk_in, rx_line_clk_in, liu_rec_clk_in, framer_tx_clk_in} & ~clks_q)};
		next_calm = (wr_en_in || mux_pin_in != pin_q) ? 3'h0 : calm + {2'h0, calm != 3'h7};
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			{shadow, hist, clks_q, calm, pin_q} <= '0;
		end
		else
		begin
			shadow <= next_shadow;
			hist   <= next_hist;
			clks_q <= {tx_clk_in, rx_line_clk_in, liu_rec_clk_in, framer_tx_clk_in};
			calm   <= next_calm;
			pin_q  <= mux_pin_in;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_reset_clear;
		$rose(rst_n_in) |-> rd_data_out == 8'h00 && !tx_user_ignore_out && !tx_power_down_out;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
	property p_reg_read;
		rd_en_in && ce_in && addr_in == tlbc_pkg::LOOPBACK_CONTROL_ADDR |=> rd_data_out == $past(shadow);
	endproperty
	a_reg_read: assert property (p_reg_read) else $error("register read mismatch");
	property p_unmapped;
		rd_en_in && ce_in && addr_in != tlbc_pkg::LOOPBACK_CONTROL_ADDR |=> rd_data_out == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_liu_join;
		calm == 3'h7 |-> liu_joined_out == ((shadow[7] || mux_pin_in) && !shadow[4]);
	endproperty
	a_liu_join: assert property (p_liu_join) else $error("join state wrong");
	property p_power_down;
		calm == 3'h7 |-> tx_power_down_out == (shadow[7] && mux_pin_in);
	endproperty
	a_power_down: assert property (p_power_down) else $error("power-down state wrong");
	property p_chan_low;
		tx_payload_loop_out |-> !tx_chan_clk_out && !tx_chan_block_out;
	endproperty
	a_chan_low: assert property (p_chan_low) else $error("channel outputs not low");
	property p_frame_edge;
		$changed(tx_user_ignore_out) |-> $past(tx_frame_start_in, 2) || $past(rx_frame_start_in, 2);
	endproperty
	a_frame_edge: assert property (p_frame_edge) else $error("loop changed off frame start");
	property p_line_timing;
		$changed(line_tx_pos_out) |-> |hist[6:1];
	endproperty
	a_line_timing: assert property (p_line_timing) else $error("line data moved off clock");
endmodule : tlbc_loopback_chk

bind tlbc_loopback tlbc_loopback_chk u_chk (.clk_in, .rst_n_in, .ce_in, .addr_in, .wr_data_in, .wr_en_in,
	.rd_en_in, .rd_data_out, .tx_clk_in, .rx_line_clk_in, .liu_rec_clk_in, .framer_tx_clk_in, .mux_pin_in,
	.tx_frame_start_in, .rx_frame_start_in, .line_tx_pos_out, .tx_chan_clk_out, .tx_chan_block_out,
	.tx_user_ignore_out, .tx_payload_loop_out, .liu_joined_out, .tx_power_down_out);

// ---- verif/tlbc_loopback_tb.sv ----
// Self-checking bench for the loopback selector.
// Assumes the design package, line model and checker are compiled first.
`timescale 1ns/10ps

module tlbc_loopback_tb;
	logic       clk_in, rst_n_in, ce_in, wr_en_in, rd_en_in, t1_mode_in, mux_pin_in;
	logic       tx_clk_in = 1'b0, rx_line_clk_in = 1'b0, framer_tx_clk_in = 1'b0;
	logic       fmt_pos_in = 1'b0, fmt_neg_in = 1'b0;
	logic       liu_rec_clk_in, line_rx_pos_in, line_rx_neg_in;
	logic       liu_rx_pos_in, liu_rx_neg_in, framer_tx_pos_in, framer_tx_neg_in;
	logic       fmt_chan_clk_in, fmt_chan_block_in, tx_frame_start_in, rx_frame_start_in;
	logic       line_tx_pos_out, line_tx_neg_out, tx_link_clk_out, tx_chan_clk_out, tx_chan_block_out;
	logic       rx_fr_pos_out, rx_fr_neg_out, rx_fr_clk_out, tx_user_ignore_out, tx_payload_loop_out;
	logic       liu_joined_out, tx_power_down_out;
	logic [7:0] addr_in, wr_data_in, rd_data_out, modes[2], e;
	logic [1:0] q[$];
	int         fail_count, compares, ones;
	int         cycles = 0;
	int         div = 0;

	tlbc_loopback dut (.*);
	tlbc_line_model u_line (.rec_clk_out(liu_rec_clk_in), .rx_pos_out(liu_rx_pos_in), .rx_neg_out(liu_rx_neg_in));

	// --------
	// Clock, timeout, pin clocks and random pins
	// --------
	initial
	begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			close_out();
		end
	end

	// Transmit clock at 160 ns; its data moves on its falling edge
	always @(negedge clk_in)
	begin
		div <= div + 1;
		{fmt_chan_clk_in, fmt_chan_block_in, line_rx_pos_in, line_rx_neg_in, framer_tx_pos_in,
			framer_tx_neg_in} <= 6'($urandom);
		if (div % 16 == 15) tx_clk_in <= ~tx_clk_in;
		if (div % 16 == 15 && tx_clk_in) {fmt_pos_in, fmt_neg_in} <= 2'($urandom);
		if (div % 12 == 0) framer_tx_clk_in <= ~framer_tx_clk_in;
		if (div % 20 == 0) rx_line_clk_in <= ~rx_line_clk_in;
	end

	// --------
	// Tasks
	// --------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		{addr_in, wr_data_in, wr_en_in} = {a, d, 1'b1};
		@(negedge clk_in);
		wr_en_in = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_in);
		{addr_in, rd_en_in} = {a, 1'b1};
		@(negedge clk_in);
		rd_en_in = 1'b0;
		check(rd_data_out, exp);
	endtask : rd

	task automatic fs(input logic rx);
		@(negedge clk_in);
		{rx_frame_start_in, tx_frame_start_in} = {rx, ~rx};
		@(negedge clk_in);
		{rx_frame_start_in, tx_frame_start_in} = 2'b00;
	endtask : fs

	task automatic bit_wait();
		@(posedge tx_clk_in);
		repeat (7) @(negedge clk_in);
	endtask : bit_wait

	task automatic close_out();
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	// --------
	// Main sequence
	// --------
	initial
	begin
		{rst_n_in, wr_en_in, rd_en_in, t1_mode_in, mux_pin_in} = '0;
		{tx_frame_start_in, rx_frame_start_in} = '0;
		{addr_in, wr_data_in, fail_count, compares} = '0;
		ce_in = 1'b1;
		modes = '{8'h81, 8'h88};
		void'($urandom(16));
		repeat (5) @(negedge clk_in);
		rst_n_in = 1'b1;
		rd(8'h4a, 8'h00);
		wr(8'h4a, 8'h9f);
		rd(8'h4a, 8'h9f);
		// Clock enable low must freeze the register
		ce_in = 1'b0;
		wr(8'h4a, 8'h01);
		ce_in = 1'b1;
		rd(8'h4a, 8'h9f);
		rd(8'h4b, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			wr(8'h4a, {i[2], 2'b00, i[1], 4'h0});
			mux_pin_in = i[0];
			repeat (8) @(negedge clk_in);
			check(liu_joined_out, (i[2] | i[0]) & ~i[1]);
			check(tx_power_down_out, i[2] & i[0]);
		end
		// Payload loop run in E1 only, so T1 framing advice is moot
		wr(8'h4a, 8'h02);
		repeat (4) @(negedge clk_in);
		check(tx_user_ignore_out, 1'b0);
		fs(1'b1);
		repeat (2) @(negedge clk_in);
		check(tx_user_ignore_out, 1'b1);
		repeat (8)
		begin
			repeat (5) @(negedge clk_in);
			check({tx_chan_clk_out, tx_chan_block_out}, 2'b00);
		end
		// Payload window opens after the E1 overhead slot
		fs(1'b0);
		repeat (2) @(negedge clk_in);
		check(tx_payload_loop_out, 1'b0);
		repeat (tlbc_pkg::E1_FRAME_BITS - tlbc_pkg::E1_PAYLOAD_BITS) @(posedge liu_rec_clk_in);
		repeat (14) @(negedge clk_in);
		check(tx_payload_loop_out, 1'b1);
		check(tx_link_clk_out, 1'b1);
		check({tx_chan_clk_out, tx_chan_block_out}, 2'b00);
		wr(8'h4a, 8'h00);
		fs(1'b1);
		t1_mode_in = 1'b1;
		foreach (modes[m])
		begin
			wr(8'h4a, modes[m]);
			fs(1'b0);
			ones = 0;
			repeat (8)
			begin
				bit_wait();
				if (m == 0)
				begin
					check({rx_fr_pos_out, rx_fr_neg_out}, {fmt_pos_in, fmt_neg_in});
					check(rx_fr_clk_out, 1'b1);
				end
				else
				begin
					// Receive side keeps the recovered clock in local loop
					e = {7'h00, fmt_pos_in};
					check(line_tx_pos_out, fmt_pos_in);
					@(posedge liu_rec_clk_in);
					repeat (7) @(negedge clk_in);
					check(rx_fr_pos_out, e);
				end
				ones += line_tx_pos_out;
			end
			if (m == 0) check(8'(ones), 8'h04);
		end
		t1_mode_in = 1'b0;
		wr(8'h4a, 8'h81);
		fs(1'b0);
		repeat (4)
		begin
			bit_wait();
			check({line_tx_pos_out, line_tx_neg_out}, {fmt_pos_in, fmt_neg_in});
		end
		wr(8'h4a, 8'h84);
		fs(1'b0);
		repeat (6)
		begin
			@(posedge liu_rec_clk_in);
			q.push_back({liu_rx_pos_in, liu_rx_neg_in});
			repeat (7) @(negedge clk_in);
			check({line_tx_pos_out, line_tx_neg_out}, {6'h00, q.pop_front()});
			check(tx_user_ignore_out, 1'b1);
		end
		rst_n_in = 1'b0;
		repeat (3) @(negedge clk_in);
		rst_n_in = 1'b1;
		rd(8'h4a, 8'h00);
		close_out();
	end
endmodule : tlbc_loopback_tb
